/* File: hw/msm_pkg.sv */
// Constants shared by both ends of the memory select and page map link.
// Assumes one clock and a synchronous active-high reset on both ends.
// Notes on behaviour
// (RULE1) Main protect bits 3..0 flag protected sectors
// (RULE2) Boot protect bits 1..0 flag boot sectors
// (RULE3) Boot protect bit 7 shows readout lock
// (RULE4) SRAM enabled only while its select high
// (RULE5) Sector selects never exceed physical sector size
// (RULE6) Equal-priority spaces never overlap each other
// (RULE7) Boot sector wins over main sector
// (RULE8) SRAM, registers, peripherals win over flash
// (RULE9) Space map bits gate fetch and read
// (RULE10) Space map boots configured, rewritable, immediate
// (RULE11) Value 0Ch gives separate program, data spaces
// (RULE12) Bits 2 and 4 combine main flash
// (RULE13) Page register read/write at offset E0h
// (RULE14) Page bits feed the address decoder
// (RULE15) Spare page bits go to logic array
// (RULE16) Protection registers read-only, writes ignored
// (RULE17) Protection registers live in register space
// (RULE18) Unmatched or blocked access enables no memory
package msm_pkg;
  localparam int ADDR_W = 16;
  localparam int REG_OFF_W = 8;
  localparam logic [7:0] OFF_PAGE = 8'hE0;
  localparam logic [7:0] OFF_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFF_BOOT_PROT = 8'hC2;
  localparam logic [7:0] OFF_SPACE_MAP = 8'hE2;
  localparam int SM_SRAM_CODE = 0;
  localparam int SM_BOOT_CODE = 1;
  localparam int SM_MAIN_CODE = 2;
  localparam int SM_BOOT_DATA = 3;
  localparam int SM_MAIN_DATA = 4;
  localparam int SM_PERIPHERAL_IO_ENABLE = 7;
  localparam logic [7:0] SM_USED_MASK = 8'h9F;
  localparam logic [7:0] SM_SEPARATE = 8'h0C;
  localparam logic [7:0] SM_BOOT_DEFAULT = 8'h0C;
  localparam int BOOT_LOCK_BIT = 7;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int MAIN_SECTORS = 4;
  localparam int BOOT_SECTORS = 2;
  localparam int PERIPH_SELECTS = 2;
  typedef enum logic [2:0] {
    MSM_TGT_NONE, MSM_TGT_MAIN, MSM_TGT_BOOT, MSM_TGT_SRAM, MSM_TGT_REGS, MSM_TGT_PERIPH
  } msm_target_t;
endpackage : msm_pkg

/* File: hw/msm_link_if.sv */
// Bus between the core and the memory select block.
// Assumes both ends share clk_i; the testbench supplies it.
`timescale 1ns/100ps
interface msm_link_if (input wire logic clk_i);
  import msm_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic fetch_strobe;
  logic read_strobe;
  logic write_strobe;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (input clk_i, output addr, output fetch_strobe, output read_strobe, output write_strobe,
    output wdata, input rdata);
  modport dev (input clk_i, input addr, input fetch_strobe, input read_strobe, input write_strobe,
    input wdata, output rdata);
endinterface : msm_link_if

/* File: hw/msm_map.sv */
// Memory select, priority, space map gating, page and protection registers.
// Assumes the core drives one strobe at a time and the select equations come in as decoded levels
// computed by the user side from address and page bits.
`timescale 1ns/100ps
module msm_map
  import msm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  msm_link_if.dev link,
  input wire logic [REG_OFF_W-1:0] reg_base_i,
  input wire logic [MAIN_SECTORS-1:0] main_sector_selects_i,
  input wire logic [BOOT_SECTORS-1:0] boot_sector_selects_i,
  input wire logic [1:0] sram_terms_i,
  input wire logic [PERIPH_SELECTS-1:0] periph_selects_i,
  input wire logic [MAIN_SECTORS-1:0] main_prot_i,
  input wire logic [BOOT_SECTORS-1:0] boot_prot_i,
  input wire logic readout_lock_i,
  input wire logic [7:0] space_map_boot_i,
  output logic [MAIN_SECTORS-1:0] main_enable_o,
  output logic [BOOT_SECTORS-1:0] boot_enable_o,
  output logic sram_enable_o,
  output logic regs_enable_o,
  output logic [PERIPH_SELECTS-1:0] periph_enable_o,
  output logic [7:0] page_bits_o,
  output logic [7:0] logic_array_page_o,
  output logic [7:0] space_map_o,
  output logic [7:0] link_rdata_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] page_q;
  logic [7:0] space_map_q;
  logic boot_done_q;
  logic [7:0] rdata_q;
  logic [MAIN_SECTORS-1:0] main_en_q;
  logic [BOOT_SECTORS-1:0] boot_en_q;
  logic sram_en_q;
  logic regs_en_q;
  logic [PERIPH_SELECTS-1:0] periph_en_q;
  logic [1:0] mp_s1_q, mp_s2_q;
  logic [MAIN_SECTORS-1:0] mpr_s1_q, mpr_s2_q;
  logic lock_s1_q, lock_s2_q;
  logic [7:0] main_prot_reg;
  logic [7:0] boot_prot_reg;
  logic regs_hit;
  logic [REG_OFF_W-1:0] off;
  logic any_strobe;
  msm_target_t tgt;

  // Register space is the top byte of address matching reg_base_i
  assign regs_hit = (link.addr[ADDR_W-1:REG_OFF_W] == reg_base_i);
  assign off = link.addr[REG_OFF_W-1:0];
  assign any_strobe = link.fetch_strobe | link.read_strobe | link.write_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // Protection status pins come from the non-volatile side, so they are synchronised
  always_ff @(posedge clk_i) begin
    mpr_s1_q <= main_prot_i;
    mpr_s2_q <= mpr_s1_q;
    mp_s1_q <= boot_prot_i;
    mp_s2_q <= mp_s1_q;
    lock_s1_q <= readout_lock_i;
    lock_s2_q <= lock_s1_q;
  end

  assign main_prot_reg = {4'h0, mpr_s2_q}; // RULE1
  assign boot_prot_reg = {lock_s2_q, 5'h00, mp_s2_q}; // RULE2 RULE3

  ////////////////////////////////////////////////////////////////////////////
  // Space map takes its configured value on the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      space_map_q <= SM_SEPARATE;
      boot_done_q <= 1'b0;
    end else if (!boot_done_q) begin
      space_map_q <= space_map_boot_i & SM_USED_MASK; // RULE10
      boot_done_q <= 1'b1;
    end else if (link.write_strobe && regs_hit && off == OFF_SPACE_MAP) begin
      space_map_q <= link.wdata & SM_USED_MASK; // RULE10
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      page_q <= PAGE_RESET;
    end else if (link.write_strobe && regs_hit && off == OFF_PAGE) begin
      page_q <= link.wdata; // RULE13
    end
  end
  // Writes to the protection offsets fall through untouched RULE16

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (link.read_strobe && regs_hit) begin
      unique case (off)
        OFF_PAGE: rdata_q <= page_q; // RULE13
        OFF_SPACE_MAP: rdata_q <= space_map_q;
        OFF_MAIN_PROT: rdata_q <= main_prot_reg; // RULE17
        OFF_BOOT_PROT: rdata_q <= boot_prot_reg; // RULE17
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed priority: regs over SRAM over peripherals over boot over main
  always_comb begin
    tgt = MSM_TGT_NONE;
    if (!any_strobe) begin
      tgt = MSM_TGT_NONE; // RULE18
    end else if (regs_hit) begin
      tgt = MSM_TGT_REGS; // RULE8
    end else if (|sram_terms_i) begin
      tgt = MSM_TGT_SRAM; // RULE4 RULE8
    end else if (|periph_selects_i && space_map_q[SM_PERIPHERAL_IO_ENABLE]) begin
      tgt = MSM_TGT_PERIPH; // RULE8 RULE9
    end else if (|boot_sector_selects_i) begin
      tgt = MSM_TGT_BOOT; // RULE7
    end else if (|main_sector_selects_i) begin
      tgt = MSM_TGT_MAIN;
    end
  end

  // Strobe gating; data reads always reach SRAM, fetch needs its bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      main_en_q <= '0;
      boot_en_q <= '0;
      sram_en_q <= 1'b0;
      regs_en_q <= 1'b0;
      periph_en_q <= '0;
    end else begin
      main_en_q <= (tgt == MSM_TGT_MAIN &&
        ((link.fetch_strobe && space_map_q[SM_MAIN_CODE]) ||
         (link.read_strobe && space_map_q[SM_MAIN_DATA]) || link.write_strobe))
        ? main_sector_selects_i : '0; // RULE9 RULE11 RULE12 RULE18
      boot_en_q <= (tgt == MSM_TGT_BOOT &&
        ((link.fetch_strobe && space_map_q[SM_BOOT_CODE]) ||
         (link.read_strobe && space_map_q[SM_BOOT_DATA]) || link.write_strobe))
        ? boot_sector_selects_i : '0; // RULE9 RULE11 RULE18
      sram_en_q <= tgt == MSM_TGT_SRAM &&
        (link.read_strobe || link.write_strobe || (link.fetch_strobe && space_map_q[SM_SRAM_CODE])); // RULE4 RULE9
      regs_en_q <= tgt == MSM_TGT_REGS && !link.fetch_strobe;
      periph_en_q <= (tgt == MSM_TGT_PERIPH && !link.fetch_strobe) ? periph_selects_i : '0;
    end
  end

  assign main_enable_o = main_en_q;
  assign boot_enable_o = boot_en_q;
  assign sram_enable_o = sram_en_q;
  assign regs_enable_o = regs_en_q;
  assign periph_enable_o = periph_en_q;
  assign page_bits_o = page_q; // RULE14
  assign logic_array_page_o = page_q; // RULE15
  assign space_map_o = space_map_q;
  assign link.rdata = rdata_q;
  assign link_rdata_o = rdata_q;
endmodule : msm_map

/* File: hw/msm_core_end.sv */
// Core-side end: turns user requests into one-cycle strobes on the link.
// Assumes user requests are on clk_i and one is issued at a time.
`timescale 1ns/100ps
module msm_core_end
  import msm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  msm_link_if.core link,
  input wire logic req_i,
  input wire logic [1:0] kind_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {MSM_IDLE, MSM_STROBE, MSM_WAIT} msm_state_t;
  msm_state_t state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [1:0] kind_q;
  logic done_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= MSM_IDLE;
      addr_q <= '0;
      wdata_q <= 8'h00;
      kind_q <= 2'h0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        MSM_IDLE: if (req_i) begin
          addr_q <= addr_i;
          wdata_q <= wdata_i;
          kind_q <= kind_i;
          state_q <= MSM_STROBE;
        end
        MSM_STROBE: state_q <= MSM_WAIT;
        MSM_WAIT: begin
          // Read data stands on the link from the cycle after the strobe
          rdata_q <= link.rdata;
          done_q <= 1'b1;
          state_q <= MSM_IDLE;
        end
      endcase
    end
  end

  // kind: 0 fetch, 1 read, 2 write, 3 ignored
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.fetch_strobe = state_q == MSM_STROBE && kind_q == 2'h0;
  assign link.read_strobe = state_q == MSM_STROBE && kind_q == 2'h1;
  assign link.write_strobe = state_q == MSM_STROBE && kind_q == 2'h2; // RULE10
  assign busy_o = state_q != MSM_IDLE;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
endmodule : msm_core_end

/* File: bench/msm_link_assertions.sv */
// Checker on the link between core end and map, plus map outputs.
// Assumes tb instantiates it beside the link interface.
`timescale 1ns/100ps
module msm_link_assertions
  import msm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic fetch_strobe,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] wdata,
  input wire logic [7:0] reg_base_i,
  input wire logic [1:0] sram_terms_i,
  input wire logic [MAIN_SECTORS-1:0] main_enable_o,
  input wire logic [BOOT_SECTORS-1:0] boot_enable_o,
  input wire logic sram_enable_o,
  input wire logic [7:0] page_bits_o,
  input wire logic [7:0] logic_array_page_o,
  input wire logic [7:0] space_map_o,
  input wire logic [MAIN_SECTORS-1:0] main_sel_i,
  input wire logic [BOOT_SECTORS-1:0] boot_sel_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////
  sequence s_page_wr; write_strobe && addr == {reg_base_i, OFF_PAGE}; endsequence
  sequence s_map_wr; write_strobe && addr == {reg_base_i, OFF_SPACE_MAP}; endsequence
  sequence s_strobe; fetch_strobe || read_strobe || write_strobe; endsequence
  property p_page_wr; s_page_wr |=> page_bits_o == $past(wdata); endproperty
  property p_map_wr; s_map_wr |=> space_map_o == ($past(wdata) & SM_USED_MASK); endproperty
  property p_sram_sel; sram_enable_o |-> $past(sram_terms_i) != 2'h0; endproperty
  property p_flash_yield;
    s_strobe ##0 (sram_terms_i != 2'h0) |=> main_enable_o == 4'h0 && boot_enable_o == 2'h0;
  endproperty
  property p_boot_wins;
    s_strobe ##0 (boot_sel_i != 2'h0 && main_sel_i != 4'h0) |=> main_enable_o == 4'h0;
  endproperty
  property p_fetch_gate; fetch_strobe && !space_map_o[SM_MAIN_CODE] |=> main_enable_o == 4'h0; endproperty
  property p_read_gate; read_strobe && !space_map_o[SM_BOOT_DATA] |=> boot_enable_o == 2'h0; endproperty
  property p_spare_page; logic_array_page_o == page_bits_o; endproperty
  a_page_wr: assert property (p_page_wr) else $error("page write lost");
  a_map_wr: assert property (p_map_wr) else $error("space map write not applied");
  a_sram_sel: assert property (p_sram_sel) else $error("sram enabled without select");
  a_flash_yield: assert property (p_flash_yield) else $error("flash enabled beside sram");
  a_boot_wins: assert property (p_boot_wins) else $error("main enabled beside boot");
  a_fetch_gate: assert property (p_fetch_gate) else $error("blocked fetch reached main");
  a_read_gate: assert property (p_read_gate) else $error("blocked read reached boot");
  a_spare_page: assert property (p_spare_page) else $error("logic array page differs");
endmodule : msm_link_assertions

/* File: bench/tb.sv */
// Testbench joining core end and map through the link interface.
// Assumes register space at upper byte F0, sectors decoded by the bench.
`timescale 1ns/100ps
module tb;
  import msm_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, req_i = 1'b0, lock = 1'b1;
  logic [1:0] kind_i = 2'h3, bsel = 2'h0, bprot = 2'h1, sterm = 2'h0, psel = 2'h0, boot_en, per_en;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rd, d, page, lpage, smap, rdo, sm, lrd;
  logic [3:0] msel = 4'h0, mprot = 4'hA, main_en;
  logic sram_en, regs_en, busy, done;
  logic [9:0] seen;
  int n_errors = 0, num_checks = 0, cyc = 0;
  msm_link_if msm_link_if_inst (.clk_i(clk_i));
  msm_core_end msm_core_end_inst (.clk_i(clk_i), .reset_i(reset_i), .link(msm_link_if_inst), .req_i(req_i),
    .kind_i(kind_i), .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy), .done_o(done), .rdata_o(rdo));
  msm_map msm_map_inst (.clk_i(clk_i), .reset_i(reset_i), .link(msm_link_if_inst), .reg_base_i(8'hF0),
    .main_sector_selects_i(msel), .boot_sector_selects_i(bsel), .sram_terms_i(sterm),
    .periph_selects_i(psel), .main_prot_i(mprot), .boot_prot_i(bprot), .readout_lock_i(lock),
    .space_map_boot_i(8'hFF), .main_enable_o(main_en), .boot_enable_o(boot_en), .sram_enable_o(sram_en),
    .regs_enable_o(regs_en), .periph_enable_o(per_en), .page_bits_o(page), .logic_array_page_o(lpage),
    .space_map_o(smap), .link_rdata_o(lrd));
  msm_link_assertions msm_link_assertions_inst (.clk_i(clk_i), .reset_i(reset_i),
    .addr(msm_link_if_inst.addr), .fetch_strobe(msm_link_if_inst.fetch_strobe),
    .read_strobe(msm_link_if_inst.read_strobe), .write_strobe(msm_link_if_inst.write_strobe),
    .wdata(msm_link_if_inst.wdata), .reg_base_i(8'hF0), .sram_terms_i(sterm), .main_enable_o(main_en),
    .boot_enable_o(boot_en), .sram_enable_o(sram_en), .page_bits_o(page), .logic_array_page_o(lpage),
    .space_map_o(smap), .main_sel_i(msel), .boot_sel_i(bsel));
  //////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Enables are collected over the whole transfer, since they stand one cycle only
  task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] v);
    int i;
    seen = 10'h000;
    req_i <= 1'b1;
    kind_i <= k;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    req_i <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      @(negedge clk_i);
      seen = seen | {main_en, boot_en, sram_en, regs_en, per_en};
    end
    rd = rdo;
    @(posedge clk_i);
  endtask : op
  // Order of bits: main[3:0], boot[1:0], sram, regs, periph[1:0]
  function automatic logic [9:0] exp_en(input logic [1:0] k, input logic [15:0] a, input logic [7:0] m);
    logic f;
    f = (k == 2'h0);
    if (k == 2'h3) return 10'h000;
    if (a[15:8] == 8'hF0) return f ? 10'h000 : 10'h004;
    if (|sterm) return (!f || m[0]) ? 10'h008 : 10'h000;
    if (|psel && m[7]) return f ? 10'h000 : {8'h00, psel};
    if (|bsel) return (k == 2'h2 || (f ? m[1] : m[3])) ? {4'h0, bsel, 4'h0} : 10'h000;
    if (|msel && (k == 2'h2 || (f ? m[2] : m[4]))) return {msel, 6'h00};
    return 10'h000;
  endfunction : exp_en
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1AD3));
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    op(2'h1, 16'hF0E2, 8'h00); chk(rd, 8'h9F);
    op(2'h1, 16'hF0C0, 8'h00); chk(rd, 8'h0A);
    op(2'h1, 16'hF0C2, 8'h00); chk(rd, 8'h81);
    op(2'h2, 16'hF0C0, 8'hFF);
    op(2'h1, 16'hF0C0, 8'h00); chk(rd, 8'h0A);
    op(2'h0, 16'hF0E0, 8'h00); chk(seen, 10'h000);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      op(2'h2, 16'hF0E0, d); chk(page, d);
      op(2'h1, 16'hF0E0, 8'h00); chk(rd, d);
    end
    for (int i = 0; i < 40; i++) begin
      sm = (i == 0) ? 8'h0C : (i == 1) ? 8'h14 : (i == 2) ? 8'h00 : 8'($urandom);
      op(2'h2, 16'hF0E2, sm);
      op(2'h1, 16'hF0E2, 8'h00); chk(rd, sm & 8'h9F);
      chk(lrd, sm & 8'h9F);
      for (int k = 0; k < 4; k++) begin
        msel <= 4'h1 << ($urandom % 5);
        bsel <= 2'h1 << ($urandom % 3);
        sterm <= (i < 3) ? 2'h0 : 2'($urandom);
        psel <= 2'h0;
        @(posedge clk_i);
        if (sterm == 2'h0 && k != 0) psel <= 2'($urandom);
        @(posedge clk_i);
        op(2'(k), {8'h10, 8'($urandom)}, 8'($urandom));
        chk(seen, exp_en(2'(k), 16'h1000, sm));
      end
    end
    conclude();
  end
endmodule : tb
